// ===== logic/i2cs_pkg.sv
/*
  Shared constants and carrier types of the two-wire slave serial port.
  Assumes a 32-bit Avalon-MM slave with byte addresses and one register per word.
*/
package i2cs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_OWN_ADDR = 5'h0c;
  localparam logic [4:0] OFS_TIMEOUT = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Field codes and reset values
  localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
  localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h7;
  localparam logic [7:0] MODE_POR = 8'he0;
  localparam logic [7:0] STATUS_POR = 8'h81;
  localparam logic [7:0] OWN_ADDR_POR = 8'h00;
  localparam logic [7:0] TIMEOUT_POR = 8'h00;
  localparam logic [7:0] STATUS_SW_MASK = 8'h1a;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Glitch filter lengths in system clocks
  localparam logic [2:0] FILT_SHORT = 3'h2;
  localparam logic [2:0] FILT_LONG = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Time-out: sub-clock periods per selection step
  localparam logic [11:0] TO_STEP = 12'h020;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [2:0] opModeSel;
    logic unused;
    logic [1:0] glitchFilterSel;
    logic moduleOn;
    logic spiIncompleteFlag;
  } i2cs_mode_t;

  typedef struct packed {
    logic byteDoneFlag;
    logic addrHitFlag;
    logic busOccupiedFlag;
    logic transmitDirSel;
    logic ackOutBit;
    logic masterReadFlag;
    logic matchWakeupEn;
    logic ackInBit;
  } i2cs_status_t;

  typedef struct packed {
    logic timeoutOn;
    logic timeoutFlag;
    logic [5:0] timeoutSel;
  } i2cs_timeout_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_RX = 8'h08,
    ST_RX_ACK = 8'h10,
    ST_TX = 8'h20,
    ST_TX_ACK = 8'h40,
    ST_SKIP = 8'h80
  } i2cs_state_t;

endpackage : i2cs_pkg

// ===== logic/i2cs_pin_filter.sv
/*
  Two-flop synchroniser followed by a selectable glitch filter for one pin.
  Assumes the pin is asynchronous to clk; sel 00 none, 01 two clocks, 1x four.
*/
`timescale 1ns/1ps
module i2cs_pin_filter (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic pinIn,
  input wire logic [1:0] sel,
  output logic level
);

  logic sync1;
  logic sync2;
  logic [2:0] stableCnt;
  wire logic [2:0] need;
  wire logic [2:0] stableNext;

  assign need = sel[1] ? i2cs_pkg::FILT_LONG : i2cs_pkg::FILT_SHORT;
  assign stableNext = 3'(stableCnt + 3'h1);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else if (ce) begin
      sync1 <= pinIn;
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filter: level follows only after the new value stands long enough
  always_ff @(posedge clk) begin
    if (reset) begin
      level <= 1'b1;
      stableCnt <= 3'h0;
    end else if (ce) begin
      if (sync2 == level) begin
        stableCnt <= 3'h0;
      end else if (sel == 2'h0 || stableNext >= need) begin
        level <= sync2;
        stableCnt <= 3'h0;
      end else begin
        stableCnt <= stableNext;
      end
    end
  end

endmodule : i2cs_pin_filter

// ===== logic/i2cs_serial_port.sv
/*
  Slave-only two-wire serial port with Avalon-MM register access.
  Assumes open-drain pads outside, an external bus master, a sub-clock input
  asynchronous to clk, and software that services the port after each event.
*/
// What this block does
// RULE1: Own address sits in bits 7..1; bit 0 is plain read/write storage.
// RULE2: Own address shares its location with the SPI second control register.
// RULE3: Mode field picks SPI or two-wire slave; 110 two-wire; resets to 111.
// RULE4: Filter select: 00 none, 01 two clocks, 1x four clocks on serial clock.
// RULE5: Module off releases both pins and idles the port.
// RULE6: On enable, direction and ack-out keep; status flags return to defaults.
// RULE7: Byte-done flag low while shifting, set after eight bits; resets high.
// RULE8: Address-hit flag set on own-address match, low otherwise.
// RULE9: Bus-occupied flag set on START, cleared on STOP.
// RULE10: Direction bit 1 makes the port transmit, 0 receive.
// RULE11: After eight received bits, ack-out bit is driven in the ninth clock.
// RULE12: Eighth bit after START is stored as the master-read flag.
// RULE13: With wake enable set, an address match wakes the core.
// RULE14: Transmitter samples ninth-clock ack; on no-ack it releases data line.
// RULE15: START is a falling data line while the clock stays high.
// RULE16: Seven address bits arrive MSB first and are compared with own address.
// RULE17: Match raises the interrupt, sets address-hit and acks low.
// RULE18: One interrupt from match, byte done or time-out.
// RULE19: After a match the clock is held until data write or dummy read.
// RULE20: Only the external master makes START; this port never does.
// RULE21: Time-out counts from match, clears on clock fall, resets status.
// RULE22: Time-out is selection plus one times 32 sub-clock periods.
// RULE23: Unmatched address leaves both lines released and no interrupt.
`timescale 1ns/1ps
module i2cs_serial_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [4:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [3:0] avByteEnable,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic subClk,
  output logic modIrq,
  output logic wakeReq
);

  i2cs_pkg::i2cs_mode_t mode;
  i2cs_pkg::i2cs_status_t stat;
  i2cs_pkg::i2cs_timeout_t tout;
  i2cs_pkg::i2cs_state_t st;
  logic [7:0] ownAddr;
  logic [7:0] shiftData;
  logic [3:0] bitCnt;
  logic sclF;
  logic sdaF;
  logic sclPrev;
  logic sdaPrev;
  logic onPrev;
  logic subSync1;
  logic subSync2;
  logic subPrev;
  logic toActive;
  logic [11:0] toCnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  i2cs_pin_filter u_scl_filter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pinIn(sclIn),
    .sel(mode.glitchFilterSel), // RULE4
    .level(sclF)
  );

  i2cs_pin_filter u_sda_filter (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pinIn(sdaIn),
    .sel(2'h0),
    .level(sdaF)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic i2cOn = mode.moduleOn && mode.opModeSel == i2cs_pkg::MODE_TWO_WIRE; // RULE3 RULE5
  wire logic onRise = i2cOn && !onPrev;
  wire logic sclRise = sclF && !sclPrev;
  wire logic sclFall = !sclF && sclPrev;
  wire logic startSeen = i2cOn && sclF && sclPrev && sdaPrev && !sdaF; // RULE15
  wire logic stopSeen = i2cOn && sclF && sclPrev && !sdaPrev && sdaF;
  wire logic lastBit = bitCnt == i2cs_pkg::BIT_COUNT;
  wire logic addrMatch = shiftData[7:1] == ownAddr[7:1]; // RULE16
  wire logic addrDecide = i2cOn && st == i2cs_pkg::ST_ADDR && sclFall && lastBit;
  wire logic subTick = subSync2 && !subPrev;
  wire logic [11:0] toLimit = 12'(({6'h0, tout.timeoutSel} + 12'h1) * i2cs_pkg::TO_STEP); // RULE22
  wire logic toExpire = i2cOn && toActive && tout.timeoutOn && subTick
    && 12'(toCnt + 12'h1) >= toLimit; // RULE21
  wire logic busReq = avRead || avWrite;
  wire logic accept = ce && busReq && !avWaitRequest;
  wire logic wrLane = accept && avWrite && avByteEnable[0];
  wire logic wrMode = wrLane && avAddress == i2cs_pkg::OFS_MODE;
  wire logic wrStatus = wrLane && avAddress == i2cs_pkg::OFS_STATUS;
  wire logic wrData = wrLane && avAddress == i2cs_pkg::OFS_DATA;
  wire logic wrOwn = wrLane && avAddress == i2cs_pkg::OFS_OWN_ADDR; // RULE2
  wire logic wrTout = wrLane && avAddress == i2cs_pkg::OFS_TIMEOUT;
  wire logic rdData = accept && avRead && avAddress == i2cs_pkg::OFS_DATA;
  wire logic swRelease = sclOe && (stat.transmitDirSel ? wrData : rdData); // RULE19
  wire logic byteRxDone = i2cOn && st == i2cs_pkg::ST_RX && sclFall && lastBit;
  wire logic byteTxDone = i2cOn && st == i2cs_pkg::ST_TX && sclFall && bitCnt == i2cs_pkg::BIT_LAST;
  wire logic irqEvent = (addrDecide && addrMatch) || byteRxDone || byteTxDone || toExpire; // RULE18
  wire logic [7:0] modeRead = {mode.opModeSel, 1'b0, mode.glitchFilterSel, mode.moduleOn,
    mode.spiIncompleteFlag};
  wire logic [7:0] readMux =
    avAddress == i2cs_pkg::OFS_MODE ? modeRead :
    avAddress == i2cs_pkg::OFS_STATUS ? stat :
    avAddress == i2cs_pkg::OFS_DATA ? shiftData :
    avAddress == i2cs_pkg::OFS_OWN_ADDR ? ownAddr :
    avAddress == i2cs_pkg::OFS_TIMEOUT ? tout : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk) begin
    if (reset) begin
      avWaitRequest <= 1'b1;
      avReadData <= 32'h0;
    end else if (ce) begin
      avWaitRequest <= !(busReq && avWaitRequest);
      if (busReq && avWaitRequest) begin
        avReadData <= {24'h0, readMux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge history, sub-clock synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      onPrev <= 1'b0;
      subSync1 <= 1'b0;
      subSync2 <= 1'b0;
      subPrev <= 1'b0;
    end else if (ce) begin
      sclPrev <= sclF;
      sdaPrev <= sdaF;
      onPrev <= i2cOn;
      subSync1 <= subClk;
      subSync2 <= subSync1;
      subPrev <= subSync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= i2cs_pkg::MODE_POR; // RULE3
      ownAddr <= i2cs_pkg::OWN_ADDR_POR;
    end else if (ce) begin
      if (wrMode) begin
        mode <= {avWriteData[7:5], 1'b0, avWriteData[3:0]};
      end
      if (wrOwn) begin
        ownAddr <= avWriteData[7:0]; // RULE1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time-out control and counter
  always_ff @(posedge clk) begin
    if (reset) begin
      tout <= i2cs_pkg::TIMEOUT_POR;
      toActive <= 1'b0;
      toCnt <= 12'h0;
    end else if (ce) begin
      if (wrTout) begin
        tout <= avWriteData[7:0];
      end
      if (toExpire) begin
        tout.timeoutOn <= 1'b0; // RULE21
        tout.timeoutFlag <= 1'b1;
        toActive <= 1'b0;
      end else if (addrDecide && addrMatch) begin
        toActive <= 1'b1; // RULE21
        toCnt <= 12'h0;
      end else if (stopSeen || !i2cOn) begin
        toActive <= 1'b0;
      end else if (sclFall) begin
        toCnt <= 12'h0; // RULE21
      end else if (toActive && subTick) begin
        toCnt <= 12'(toCnt + 12'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine and status
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= i2cs_pkg::ST_IDLE;
      stat <= i2cs_pkg::STATUS_POR; // RULE7
      shiftData <= 8'h0;
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      modIrq <= 1'b0;
      wakeReq <= 1'b0;
    end else if (ce) begin
      modIrq <= irqEvent; // RULE18
      wakeReq <= addrDecide && addrMatch && stat.matchWakeupEn; // RULE13
      if (wrStatus) begin
        stat <= (stat & ~i2cs_pkg::STATUS_SW_MASK) | (avWriteData[7:0] & i2cs_pkg::STATUS_SW_MASK);
      end
      if (wrData) begin
        shiftData <= avWriteData[7:0];
      end
      if (swRelease) begin
        sclOe <= 1'b0; // RULE19
        bitCnt <= 4'h0;
        stat.byteDoneFlag <= 1'b0; // RULE7
        st <= stat.transmitDirSel ? i2cs_pkg::ST_TX : i2cs_pkg::ST_RX; // RULE10
        sdaOe <= stat.transmitDirSel && !avWriteData[7];
      end
      if (onRise) begin
        stat.byteDoneFlag <= 1'b1; // RULE6
        stat.addrHitFlag <= 1'b0;
        stat.busOccupiedFlag <= 1'b0;
        stat.masterReadFlag <= 1'b0;
        stat.ackInBit <= 1'b1;
      end
      if (!i2cOn) begin
        st <= i2cs_pkg::ST_IDLE; // RULE5
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else if (toExpire) begin
        stat <= i2cs_pkg::STATUS_POR; // RULE21
        st <= i2cs_pkg::ST_IDLE;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else if (startSeen) begin
        stat.busOccupiedFlag <= 1'b1; // RULE9
        stat.addrHitFlag <= 1'b0;
        st <= i2cs_pkg::ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else if (stopSeen) begin
        stat.busOccupiedFlag <= 1'b0; // RULE9
        st <= i2cs_pkg::ST_IDLE;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else begin
        unique case (st)
          i2cs_pkg::ST_IDLE, i2cs_pkg::ST_SKIP: begin
            sdaOe <= 1'b0; // RULE23
          end
          i2cs_pkg::ST_ADDR: begin
            if (sclRise) begin
              shiftData <= {shiftData[6:0], sdaF}; // RULE16
              bitCnt <= 4'(bitCnt + 4'h1);
            end else if (addrDecide) begin
              stat.masterReadFlag <= shiftData[0]; // RULE12
              bitCnt <= 4'h0;
              if (addrMatch) begin
                stat.addrHitFlag <= 1'b1; // RULE8 RULE17
                stat.byteDoneFlag <= 1'b1;
                sdaOe <= 1'b1;
                st <= i2cs_pkg::ST_ADDR_ACK;
              end else begin
                st <= i2cs_pkg::ST_SKIP; // RULE23
              end
            end
          end
          i2cs_pkg::ST_ADDR_ACK, i2cs_pkg::ST_RX_ACK: begin
            if (sclFall && !sclOe) begin
              sdaOe <= 1'b0;
              sclOe <= 1'b1; // RULE19
            end
          end
          i2cs_pkg::ST_RX: begin
            if (sclRise) begin
              shiftData <= {shiftData[6:0], sdaF};
              bitCnt <= 4'(bitCnt + 4'h1);
            end else if (byteRxDone) begin
              stat.byteDoneFlag <= 1'b1; // RULE7
              sdaOe <= !stat.ackOutBit; // RULE11
              st <= i2cs_pkg::ST_RX_ACK;
            end
          end
          i2cs_pkg::ST_TX: begin
            if (sclFall) begin
              bitCnt <= 4'(bitCnt + 4'h1);
              shiftData <= {shiftData[6:0], 1'b0};
              if (byteTxDone) begin
                stat.byteDoneFlag <= 1'b1; // RULE7
                sdaOe <= 1'b0;
                st <= i2cs_pkg::ST_TX_ACK;
              end else begin
                sdaOe <= !shiftData[6];
              end
            end
          end
          i2cs_pkg::ST_TX_ACK: begin
            if (sclRise) begin
              stat.ackInBit <= sdaF; // RULE14
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              if (stat.ackInBit) begin
                st <= i2cs_pkg::ST_SKIP; // RULE14
              end else begin
                sclOe <= 1'b1;
              end
            end
          end
          default: begin
            st <= i2cs_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  own_addr_store_a: assert property (wrOwn |=> ownAddr == $past(avWriteData[7:0])) // RULE1
    else $error("own address not stored");
  mode_reset_value_a: assert property ($fell(reset) |-> mode.opModeSel == i2cs_pkg::MODE_UNUSED) // RULE3
    else $error("mode field not 111 after reset");
  off_release_a: assert property (ce && !i2cOn |=> !sdaOe && !sclOe) // RULE5
    else $error("pins held while off");
  enable_defaults_a: assert property (ce && onRise && !toExpire && !startSeen && !stopSeen
    && !addrDecide |=> !stat.addrHitFlag && !stat.busOccupiedFlag && stat.ackInBit) // RULE6
    else $error("flags not defaulted on enable");
  start_busy_a: assert property (ce && startSeen && !toExpire |=> stat.busOccupiedFlag) // RULE9
    else $error("busy not set on start");
  stop_free_a: assert property (ce && stopSeen && !toExpire |=> !stat.busOccupiedFlag) // RULE9
    else $error("busy not cleared on stop");
  match_ack_a: assert property (ce && addrDecide && addrMatch && !toExpire
    |=> stat.addrHitFlag && sdaOe && modIrq) // RULE17
    else $error("match not acknowledged");
  match_irq_a: assert property (ce && addrDecide && addrMatch |=> modIrq) // RULE18
    else $error("no interrupt on match");
  read_bit_a: assert property (ce && addrDecide && !toExpire
    |=> stat.masterReadFlag == $past(shiftData[0])) // RULE12
    else $error("read/write bit not captured");
  miss_release_a: assert property (ce && addrDecide && !addrMatch && !toExpire
    |=> !sdaOe && !sclOe && !modIrq) // RULE23
    else $error("unmatched address touched bus");
  rx_ack_drive_a: assert property (ce && byteRxDone && !toExpire
    |=> sdaOe == !$past(stat.ackOutBit) && stat.byteDoneFlag) // RULE11
    else $error("ack-out not driven");
  hold_clock_a: assert property (ce && i2cOn && st == i2cs_pkg::ST_ADDR_ACK && sclFall && !sclOe
    && !toExpire |=> sclOe) // RULE19
    else $error("clock not held after match");
  timeout_flag_a: assert property (ce && toExpire |=> tout.timeoutFlag && !tout.timeoutOn
    && stat == i2cs_pkg::STATUS_POR && modIrq) // RULE21
    else $error("time-out not handled");

endmodule : i2cs_serial_port

// ===== testbench/i2cs_bus_master.sv
/*
  Two-wire bus master model on open-drain lines, 64 ns bit period (5 clk low, 3 high).
  Assumes pull-ups on both lines and a slave that may stretch the clock.
*/
`timescale 1ns/1ps
module i2cs_bus_master (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  int stalls = 0;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic waitHigh();
    int n;
    for (n = 0; n < 5000 && scl !== 1'b1; n++) tick(1);
    if (n == 5000) stalls++;
  endtask : waitHigh
  // Data set late in the low phase, sampled at the end of the high phase
  task automatic clockBit(input logic b, input int lead, output logic seen);
    tick(lead + 4);
    sdaLow <= !b;
    tick(1);
    sclLow <= 1'b0;
    tick(1);
    waitHigh();
    tick(2);
    seen = sda;
    sclLow <= 1'b1;
  endtask : clockBit
  ////////////////////////////////////////////////////////////
  task automatic start();
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    sclLow <= 1'b1;
  endtask : start
  task automatic stop();
    tick(2);
    sdaLow <= 1'b1;
    tick(2);
    sclLow <= 1'b0;
    tick(1);
    waitHigh();
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
  endtask : stop
  // Extra low time before each byte lets a stretching slave take the clock first
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(b[i], (i == 7) ? 8 : 0, s);
    clockBit(1'b1, 0, ack);
  endtask : writeByte
  task automatic readByte(input logic ackBit, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(1'b1, (i == 7) ? 8 : 0, b[i]);
    clockBit(ackBit, 0, s);
  endtask : readByte
endmodule : i2cs_bus_master

// ===== testbench/tb.sv
/*
  Self-checking bench of the two-wire slave port with a reference data queue.
  Assumes the package, the port module and the bus master model compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic subClk = 1'b0;
  logic [4:0] avAddress = 5'h00;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [3:0] avByteEnable = 4'h1;
  logic [31:0] avWriteData = 32'h0;
  logic [31:0] avReadData, x;
  logic avWaitRequest, sclOe, sdaOe, modIrq, wakeReq, mSclLow, mSdaLow, ack;
  wire logic scl = !(mSclLow || sclOe);
  wire logic sda = !(mSdaLow || sdaOe);
  int mismatches = 0;
  int checks = 0;
  int irqs = 0;
  int wakes = 0;
  int subEdges = 0;
  int n, sel;
  logic [7:0] own, d, r, rq[$];
  always #4 clk = ~clk;
  always #24 subClk = ~subClk;
  always @(posedge subClk) subEdges++;
  always @(posedge clk) begin
    if (modIrq === 1'b1) irqs++;
    if (wakeReq === 1'b1) wakes++;
  end
  i2cs_serial_port dut_u (.clk(clk), .reset(reset), .ce(1'b1), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avByteEnable(avByteEnable),
    .avWriteData(avWriteData), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
    .subClk(subClk), .modIrq(modIrq), .wakeReq(wakeReq));
  i2cs_bus_master m_u (.clk(clk), .scl(scl), .sda(sda), .sclLow(mSclLow), .sdaLow(mSdaLow));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    mismatches += m_u.stalls;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic hang(input string s);
    mismatches++;
    $display("BAD %s expected answer seen none", s);
    stop_test();
  endtask : hang
  task automatic chkReg(input string s, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask : chkReg
  task automatic chkBit(input string s, input logic e, input logic v);
    checks++;
    if (v !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", s, e, v);
    end
  endtask : chkBit
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    int k;
    @(posedge clk);
    avAddress <= a;
    avWriteData <= {24'h0, v};
    avWrite <= w;
    avRead <= !w;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (avWaitRequest === 1'b0) break;
    end
    x = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    if (k == 100) hang("waitrequest");
  endtask : bus
  task automatic rdChk(input string s, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chkReg(s, {24'h0, e}, x);
  endtask : rdChk
  task automatic waitStretch();
    int k;
    for (k = 0; k < 2000 && sclOe !== 1'b1; k++) @(posedge clk);
    if (k == 2000) hang("stretch");
  endtask : waitStretch
  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask : endTest
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb177a21a));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdChk("mode", i2cs_pkg::OFS_MODE, i2cs_pkg::MODE_POR);
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'h81);
    rdChk("own", i2cs_pkg::OFS_OWN_ADDR, 8'h00);
    rdChk("timeout", i2cs_pkg::OFS_TIMEOUT, 8'h00);
    bus(1'b1, 5'h14, 8'hff);
    rdChk("unmapped", 5'h14, 8'h00);
    for (int m = 0; m < 8; m++) begin
      for (int f = 0; f < 4; f++) begin
        bus(1'b1, i2cs_pkg::OFS_MODE, {m[2:0], 1'b1, f[1:0], 2'b00});
        rdChk("mode", i2cs_pkg::OFS_MODE, {m[2:0], 1'b0, f[1:0], 2'b00});
      end
    end
    own = 8'($urandom);
    bus(1'b1, i2cs_pkg::OFS_OWN_ADDR, own);
    rdChk("own", i2cs_pkg::OFS_OWN_ADDR, own);
    avByteEnable <= 4'h0;
    bus(1'b1, i2cs_pkg::OFS_OWN_ADDR, ~own);
    avByteEnable <= 4'h1;
    rdChk("own", i2cs_pkg::OFS_OWN_ADDR, own);
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'hff);
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'h9b);
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h00);
    endTest("registers");
    // Port off: matching address is ignored
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc0);
    m_u.start();
    m_u.writeByte({own[7:1], 1'b0}, ack);
    m_u.stop();
    chkBit("ack", 1'b1, ack);
    chkReg("irqs", 0, irqs);
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'h81);
    endTest("off");
    // Foreign address
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc2);
    m_u.start();
    m_u.writeByte({own[7:1] ^ 7'h01, 1'b0}, ack);
    chkBit("ack", 1'b1, ack);
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'ha1);
    m_u.writeByte(8'($urandom), ack);
    chkBit("ack", 1'b1, ack);
    chkBit("sclOe", 1'b0, sclOe);
    m_u.stop();
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'ha1 & 8'hdf);
    chkReg("irqs", 0, irqs);
    endTest("mismatch");
    // Master writes two bytes; second one refused
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h02);
    m_u.start();
    m_u.writeByte({own[7:1], 1'b0}, ack);
    chkBit("ack", 1'b0, ack);
    d = 8'($urandom);
    rq.push_back(d);
    fork
      m_u.writeByte(d, ack);
      begin
        waitStretch();
        rdChk("status", i2cs_pkg::OFS_STATUS, 8'he3);
        bus(1'b0, i2cs_pkg::OFS_DATA, 8'h00);
      end
    join
    chkBit("ack", 1'b0, ack);
    chkReg("irqs", 2, irqs);
    chkReg("wakes", 1, wakes);
    d = 8'($urandom);
    fork
      m_u.writeByte(d, ack);
      begin
        waitStretch();
        bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h0a);
        rdChk("data", i2cs_pkg::OFS_DATA, rq.pop_front());
      end
    join
    rq.push_back(d);
    chkBit("ack", 1'b1, ack);
    fork
      m_u.stop();
      begin
        waitStretch();
        rdChk("data", i2cs_pkg::OFS_DATA, rq.pop_front());
      end
    join
    endTest("receive");
    // Master reads two bytes, refuses the second
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc6);
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h10);
    m_u.start();
    m_u.writeByte({own[7:1], 1'b1}, ack);
    chkBit("ack", 1'b0, ack);
    rq.push_back(8'($urandom));
    rq.push_back(8'($urandom));
    fork
      m_u.readByte(1'b0, r);
      begin
        waitStretch();
        rdChk("status", i2cs_pkg::OFS_STATUS, 8'hf5);
        bus(1'b1, i2cs_pkg::OFS_DATA, rq[0]);
        bus(1'b0, i2cs_pkg::OFS_STATUS, 8'h00);
        chkBit("done", 1'b0, x[7]);
      end
    join
    chkReg("rx", rq.pop_front(), r);
    fork
      m_u.readByte(1'b1, r);
      begin
        waitStretch();
        rdChk("status", i2cs_pkg::OFS_STATUS, 8'hf4);
        bus(1'b1, i2cs_pkg::OFS_DATA, rq[0]);
      end
    join
    chkReg("rx", rq.pop_front(), r);
    repeat (8) @(posedge clk);
    chkBit("sdaOe", 1'b0, sdaOe);
    bus(1'b0, i2cs_pkg::OFS_STATUS, 8'h00);
    chkBit("ackIn", 1'b1, x[0]);
    m_u.stop();
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h18);
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc4);
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc6);
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'h99);
    endTest("transmit");
    // Four-clock filter swallows the three-clock high pulses
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hca);
    m_u.start();
    m_u.writeByte({own[7:1], 1'b0}, ack);
    m_u.stop();
    chkBit("ack", 1'b1, ack);
    bus(1'b1, i2cs_pkg::OFS_MODE, 8'hc6);
    endTest("filter");
    // Master stalls the clock after a match
    sel = $urandom_range(3, 0);
    bus(1'b1, i2cs_pkg::OFS_STATUS, 8'h00);
    bus(1'b1, i2cs_pkg::OFS_TIMEOUT, {2'b10, sel[5:0]});
    m_u.start();
    m_u.writeByte({own[7:1], 1'b0}, ack);
    subEdges = 0;
    n = irqs;
    for (int k = 0; k < 20000 && irqs == n; k++) @(posedge clk);
    chkBit("window", 1'b1, subEdges >= (sel + 1) * 32 - 3 && subEdges <= (sel + 1) * 32 + 3);
    repeat (2) @(posedge clk);
    chkBit("sclOe", 1'b0, sclOe);
    rdChk("timeout", i2cs_pkg::OFS_TIMEOUT, {2'b01, sel[5:0]});
    rdChk("status", i2cs_pkg::OFS_STATUS, 8'h81);
    m_u.stop();
    bus(1'b1, i2cs_pkg::OFS_TIMEOUT, 8'h00);
    rdChk("timeout", i2cs_pkg::OFS_TIMEOUT, 8'h00);
    endTest("timeout");
    stop_test();
  end
endmodule : tb
